// ### verif/mbcrc_top_sva.sv
`timescale 1ns/10ps

module mbcrc_top_sva (
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        arst_n,
  // inputs
  input wire logic [31:0] seed_data,
  input wire logic        seed_load,
  input wire logic        irq_enable,
  input wire logic        err_clear,
  input wire logic        word_valid,
  // outputs
  input wire logic        word_ready,
  input wire logic [31:0] sig_value,
  input wire logic [15:0] word_count,
  input wire logic        block_done,
  input wire logic [2:0]  status,
  input wire logic        irq_req
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  a_seed_restart: assert property (seed_load |=>
    sig_value == $past(seed_data) && word_count == 16'h0000)
    else $error("seed load did not restart");
  a_ready_refused: assert property (
    (seed_load || status[2]) |-> !word_ready)
    else $error("word accepted while refused");
  a_count_step: assert property (word_valid && word_ready |=>
    word_count == $past(word_count) + 16'h0001 || status[2])
    else $error("word count did not advance");
  a_check_done: assert property (status[2] |=>
    block_done && !status[2])
    else $error("check not followed by done");
  a_done_pulse: assert property ($rose(block_done) |->
    $past(status[2]) ##1 !block_done)
    else $error("done not a single pulse after check");
  a_err_sticky: assert property (status[0] && !err_clear |=>
    status[0])
    else $error("error flag lost");
  a_err_on_done: assert property ($rose(status[0]) |->
    block_done && !status[1])
    else $error("error set outside block end");
  a_irq_gated: assert property (
    irq_req == (status[0] && $past(irq_enable)))
    else $error("irq not gated error");
endmodule

bind mbcrc_top mbcrc_top_sva u_sva (.sys_clk, .arst_n, .seed_data,
  .seed_load, .irq_enable, .err_clear, .word_valid, .word_ready,
  .sig_value, .word_count, .block_done, .status, .irq_req);

// ### verif/mbcrc_top_tb_top.sv
`timescale 1ns/10ps

module mbcrc_top_tb_top;
  import mbcrc_pkg::*;
  logic        sys_clk, arst_n, poly_load, blk_len_load, expect_load;
  logic        seed_load, irq_enable, err_clear, prng_step, word_valid;
  logic        word_ready, block_done, irq_req, mism;
  logic [31:0] poly_data, expect_data, seed_data, sig_value, block_result;
  logic [15:0] blk_len_data, word_data, word_count, w;
  logic [2:0]  status;
  logic [31:0] m, s;
  logic [15:0] wq[$];
  logic [31:0] polys [4] = '{32'h04c11db7, 32'h1edc6f41, 32'h741b8cd7,
                             32'h814141ab};
  int          n_errors, comparisons, e;

  mbcrc_top dut (.sys_clk, .arst_n, .poly_data, .poly_load, .blk_len_data,
    .blk_len_load, .expect_data, .expect_load, .seed_data, .seed_load,
    .irq_enable, .err_clear, .word_valid, .word_data, .word_ready,
    .prng_step, .sig_value, .word_count, .block_result, .block_done,
    .status, .irq_req);
  mbcrc_word_src src (.sys_clk, .word_ready, .word_valid, .word_data);

  function automatic logic [31:0] step(logic [31:0] r, p, logic [15:0] d);
    for (int i = 15; i >= 0; i--)
      r = {r[30:0], 1'b0} ^ ((r[31] ^ d[i]) ? p : 32'h00000000);
    return r;
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic final_report;
    $display("comparisons %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic pulse_cfg(input logic [31:0] p, r, x, input logic [15:0] n);
    {poly_data, seed_data, expect_data, blk_len_data} = {p, r, x, n};
    {poly_load, seed_load, expect_load, blk_len_load} = 4'hf;
    @(posedge sys_clk) #1;
    {poly_load, seed_load, expect_load, blk_len_load} = 4'h0;
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  initial begin
    {arst_n, poly_load, blk_len_load, expect_load, seed_load} = 5'h00;
    {irq_enable, err_clear, prng_step} = 3'h0;
    {poly_data, expect_data, seed_data, blk_len_data} = '0;
    void'($urandom(32'h1b12));
    repeat (6) @(posedge sys_clk);
    #1 arst_n = 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    chk("signature", sig_value, 32'h0);
    chk("count", {16'h0, word_count}, 32'h0);
    // blocks of 1,3,5,7 words, pass and fail, irq on and off
    for (int k = 0; k < 4; k++) begin
      s = $urandom;
      m = s;
      mism = k inside {1, 2};
      irq_enable = k < 2;
      for (int j = 0; j < 2 * k + 1; j++) begin
        w = 16'($urandom);
        wq.push_back(w);
        m = step(m, polys[k], w);
      end
      pulse_cfg(polys[k], s, m ^ {31'h0, mism}, 16'(2 * k + 1));
      while (wq.size() != 0)
        src.q.push_back(wq.pop_front());
      for (e = 0; e < 100 && block_done !== 1'b1; e++)
        @(posedge sys_clk) #1;
      if (e == 100) begin
        n_errors++;
        final_report;
      end
      chk("result", block_result, m);
      chk("error", {31'h0, status[0]}, {31'h0, mism});
      chk("passed", {31'h0, status[1]}, {31'h0, !mism});
      chk("irq", {31'h0, irq_req}, {31'h0, mism && k < 2});
      // one idle cycle so the error must hold on its own
      @(posedge sys_clk) #1;
      chk("error held", {31'h0, status[0]}, {31'h0, mism});
      err_clear = 1'b1;
      @(posedge sys_clk) #1;
      err_clear = 1'b0;
      chk("error cleared", {31'h0, status[0]}, 32'h0);
      chk("irq cleared", {31'h0, irq_req}, 32'h0);
    end
    s = $urandom;
    pulse_cfg(polys[1], s, 32'h0, 16'h0100);
    prng_step = 1'b1;
    @(posedge sys_clk) #1;
    prng_step = 1'b0;
    chk("random", sig_value, step(s, polys[1], 16'h0));
    chk("error", {31'h0, status[0]}, 32'h0);
    final_report;
  end
endmodule

// ### verif/mbcrc_word_src.sv
`timescale 1ns/10ps

// supplier of data words, stalls at random
module mbcrc_word_src (
  // clock
  input  wire logic        sys_clk,
  // word stream
  input  wire logic        word_ready,
  output      logic        word_valid,
  output      logic [15:0] word_data
);
  logic [15:0] q[$];
  logic        tk;

  initial begin
    word_valid = 1'b0;
    word_data  = 16'h0000;
  end

  always @(posedge sys_clk) begin
    tk = word_valid && word_ready;
    if (tk)
      void'(q.pop_front());
    #1;
    if (tk || !word_valid)
      word_valid = q.size() != 0 && ($urandom % 4) != 0;
    // idle data toggles so nothing stale looks valid
    word_data = word_valid ? q[0] : ~word_data;
  end
endmodule

// ### verilog/mbcrc_cfg.svh
`ifndef MBCRC_CFG_SVH
`define MBCRC_CFG_SVH

// reset values
`define MBCRC_POLY_RST    32'h04c11db7
`define MBCRC_BLKLEN_RST  16'h0100
`define MBCRC_EXPECT_RST  32'h00000000
`define MBCRC_SIG_RST     32'h00000000
`define MBCRC_CNT_RST     16'h0000

// field positions of the status word
`define MBCRC_STS_ERR_BIT   0
`define MBCRC_STS_PASS_BIT  1
`define MBCRC_STS_CHK_BIT   2

// timing: one cycle to compare a finished block
`define MBCRC_CHECK_CYCLES  1

`endif

// ### verilog/mbcrc_pkg.sv
package mbcrc_pkg;

  typedef enum logic [1:0] {
    MBCRC_ST_RUN   = 2'b00,
    MBCRC_ST_CHECK = 2'b01
  } mbcrc_state_type;

  typedef logic [31:0] mbcrc_sig_type;
  typedef logic [15:0] mbcrc_word_type;

endpackage

// ### verilog/mbcrc_step.sv
`timescale 1ns/10ps

// one parallel absorb of a data word, msb first, galois form
module mbcrc_step import mbcrc_pkg::*; #(
  parameter int SIG_W  = 32,
  parameter int WORD_W = 16
) (
  // operands
  input  wire logic [SIG_W-1:0]  sig_in,
  input  wire logic [SIG_W-1:0]  poly_in,
  input  wire logic [WORD_W-1:0] word_in,
  // result
  output      logic [SIG_W-1:0]  sig_out
);

  logic [SIG_W-1:0] chain [0:WORD_W];

  assign chain[0] = sig_in;

  genvar i;
  generate
    for (i = 0; i < WORD_W; i = i + 1) begin : g_bit
      wire fb;
      assign fb = chain[i][SIG_W-1] ^ word_in[WORD_W-1-i];
      assign chain[i+1] = {chain[i][SIG_W-2:0], 1'b0} ^
                          (fb ? poly_in : {SIG_W{1'b0}});
    end
  endgenerate

  assign sig_out = chain[WORD_W];

endmodule

// ### verilog/mbcrc_top.sv
`timescale 1ns/10ps
`include "mbcrc_cfg.svh"

module mbcrc_top import mbcrc_pkg::*; #(
  parameter int SIG_W  = 32,
  parameter int WORD_W = 16,
  parameter int CNT_W  = 16
) (
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              arst_n,

  // configuration
  input  wire logic [SIG_W-1:0]  poly_data,
  input  wire logic              poly_load,
  input  wire logic [CNT_W-1:0]  blk_len_data,
  input  wire logic              blk_len_load,
  input  wire logic [SIG_W-1:0]  expect_data,
  input  wire logic              expect_load,
  input  wire logic [SIG_W-1:0]  seed_data,
  input  wire logic              seed_load,
  input  wire logic              irq_enable,
  input  wire logic              err_clear,

  // data word stream
  input  wire logic              word_valid,
  input  wire logic [WORD_W-1:0] word_data,
  output      logic              word_ready,

  // pseudo-random stepping
  input  wire logic              prng_step,

  // state and results
  output      logic [SIG_W-1:0]  sig_value,
  output      logic [CNT_W-1:0]  word_count,
  output      logic [SIG_W-1:0]  block_result,
  output      logic              block_done,
  output      logic [2:0]        status,
  output      logic              irq_req
);

  // reset release through two flops
  logic rst_meta_reg;
  logic rst_sync_reg;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  wire rst_n;
  assign rst_n = rst_sync_reg;

  // state
  mbcrc_state_type state_reg;
  mbcrc_state_type state_next;

  logic [SIG_W-1:0] poly_reg;
  logic [SIG_W-1:0] poly_next;
  logic [CNT_W-1:0] blk_len_reg;
  logic [CNT_W-1:0] blk_len_next;
  logic [SIG_W-1:0] expect_reg;
  logic [SIG_W-1:0] expect_next;
  logic [SIG_W-1:0] sig_reg;
  logic [SIG_W-1:0] sig_next;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic [SIG_W-1:0] result_reg;
  logic [SIG_W-1:0] result_next;
  logic             done_reg;
  logic             done_next;
  logic             err_reg;
  logic             err_next;
  logic             pass_reg;
  logic             pass_next;
  logic             irq_reg;
  logic             irq_next;

  // decode
  wire              in_run;
  wire              in_check;
  wire              absorb;
  wire              advance;
  wire [WORD_W-1:0] feed_word;
  wire [SIG_W-1:0]  sig_stepped;
  wire [CNT_W-1:0]  cnt_inc;
  wire              block_end;
  wire              mismatch;

  assign in_run   = (state_reg == MBCRC_ST_RUN);
  assign in_check = (state_reg == MBCRC_ST_CHECK);

  // seed load takes the cycle; a word offered then waits
  assign word_ready = in_run & ~seed_load;

  assign absorb  = word_valid & word_ready;
  // prng steps only when no word is taken
  assign advance = absorb | (prng_step & in_run & ~seed_load);

  // random stepping feeds zeros, a plain lfsr advance
  assign feed_word = absorb ? word_data : {WORD_W{1'b0}};

  mbcrc_step #(
    .SIG_W  (SIG_W),
    .WORD_W (WORD_W)
  ) u_step (
    .sig_in  (sig_reg),
    .poly_in (poly_reg),
    .word_in (feed_word),
    .sig_out (sig_stepped)
  );

  assign cnt_inc = cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};

  assign block_end = absorb & (cnt_inc == blk_len_reg);

  assign mismatch = in_check & (result_reg != expect_reg);

  assign poly_next    = poly_load ? poly_data : poly_reg;
  assign blk_len_next = blk_len_load ? blk_len_data : blk_len_reg;
  assign expect_next  = expect_load ? expect_data : expect_reg;

  assign sig_next = seed_load ? seed_data :
                    advance   ? sig_stepped : sig_reg;

  assign cnt_next = seed_load ? `MBCRC_CNT_RST :
                    block_end ? `MBCRC_CNT_RST :
                    absorb    ? cnt_inc : cnt_reg;

  assign result_next = block_end ? sig_stepped : result_reg;

  assign state_next = block_end ? MBCRC_ST_CHECK :
                      in_check  ? MBCRC_ST_RUN : state_reg;

  assign done_next = in_check;

  // set beats clear so no block error is lost
  assign err_next  = mismatch | (err_reg & ~err_clear);
  assign pass_next = in_check ? (result_reg == expect_reg) : pass_reg;

  assign irq_next = err_next & irq_enable;

  // configuration registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      poly_reg    <= `MBCRC_POLY_RST;
      blk_len_reg <= `MBCRC_BLKLEN_RST;
      expect_reg  <= `MBCRC_EXPECT_RST;
    end else begin
      poly_reg    <= poly_next;
      blk_len_reg <= blk_len_next;
      expect_reg  <= expect_next;
    end
  end

  // signature and counter
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sig_reg <= `MBCRC_SIG_RST;
      cnt_reg <= `MBCRC_CNT_RST;
    end else begin
      sig_reg <= sig_next;
      cnt_reg <= cnt_next;
    end
  end

  // block sequencing
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg  <= MBCRC_ST_RUN;
      result_reg <= `MBCRC_SIG_RST;
      done_reg   <= 1'b0;
    end else begin
      case (state_reg)
        MBCRC_ST_RUN: begin
          state_reg <= state_next;
        end
        MBCRC_ST_CHECK: begin
          state_reg <= state_next;
        end
        default: begin
          state_reg <= MBCRC_ST_RUN;
        end
      endcase
      result_reg <= result_next;
      done_reg   <= done_next;
    end
  end

  // check flags
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      err_reg  <= 1'b0;
      pass_reg <= 1'b0;
      irq_reg  <= 1'b0;
    end else begin
      err_reg  <= err_next;
      pass_reg <= pass_next;
      irq_reg  <= irq_next;
    end
  end

  assign sig_value    = sig_reg;
  assign word_count   = cnt_reg;
  assign block_result = result_reg;
  assign block_done   = done_reg;
  assign irq_req      = irq_reg;

  assign status[`MBCRC_STS_ERR_BIT]  = err_reg;
  assign status[`MBCRC_STS_PASS_BIT] = pass_reg;
  assign status[`MBCRC_STS_CHK_BIT]  = in_check;

endmodule
